// ==== inc/tim_pkg.sv ====
// timer prescaler and channel event flag constants
// assumes an APB slave with 32-bit data, one word per register
package tim_pkg;
   localparam int          NUM_CH        = 8;
   localparam int          PRE_W         = 7;
   localparam int          SEL_W         = 3;
   localparam int          ADDR_W        = 12;
   // register byte addresses
   localparam logic [11:0] OFS_CTRL      = 12'h000;
   localparam logic [11:0] OFS_FLAGS     = 12'h004;
   localparam logic [11:0] OFS_STATUS    = 12'h008;
   // control register fields
   localparam int          CTRL_SEL_LSB  = 0;
   localparam int          CTRL_FFC_BIT  = 4;
   // reset values
   localparam logic [2:0]  SEL_RST       = 3'h0;
   localparam logic [7:0]  FLAGS_RST     = 8'h00;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage

// ==== hdl/tim_prescaler.sv ====
// prescaler: divides the bus clock by 2**sel and emits one tick per timer clock
// assumes sel is held stable by the parent register
`timescale 1ns/1ps
`default_nettype none
module tim_prescaler #(
   parameter int PRE_W = tim_pkg::PRE_W,
   parameter int SEL_W = tim_pkg::SEL_W
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // selector from software
   input  wire logic [SEL_W-1:0] selReq,
   // timer clock tick and active selector
   output logic                  tick,
   output logic [SEL_W-1:0]      selAct
);
   logic [PRE_W-1:0] cnt_r;
   logic [SEL_W-1:0] sel_r;
   logic [PRE_W-1:0] mask;
   logic             wrap;

   always_comb begin
      mask = PRE_W'((1 << sel_r) - 1);
   end
   // wrap when all active stages are ones, so they clear to zero at the next edge
   assign wrap = ((cnt_r & mask) == mask);

   always_ff @(posedge mclk) begin
      if (reset) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= wrap ? '0 : cnt_r + PRE_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (reset) begin
         sel_r <= tim_pkg::SEL_RST;
      end else if (wrap) begin
         sel_r <= selReq;
      end
   end

   assign tick   = wrap;
   assign selAct = sel_r;

   // next tick comes eight cycles after this one
   a_tick_period: assert property (@(posedge mclk) disable iff (reset)
      tick && sel_r == 3'h3 && selReq == 3'h3 |=> !tick [*7] ##1 tick)
      else $error("tick period wrong for divide by 8");
   a_sel_hold: assert property (@(posedge mclk) disable iff (reset)
      !$past(wrap) |-> $stable(sel_r))
      else $error("selector changed off a zero boundary");
   a_div_one: assert property (@(posedge mclk) disable iff (reset)
      sel_r == 3'h0 |-> tick)
      else $error("divide by one missed a tick");
   c_sel_change: cover property (@(posedge mclk) disable iff (reset)
      wrap && selReq != sel_r);
endmodule
`default_nettype wire

// ==== hdl/tim_channel_flags.sv ====
// APB slave: timer control, channel event flags, prescale status
// assumes channel event and access strobes are one-cycle pulses on mclk
`timescale 1ns/1ps
`default_nettype none
module tim_channel_flags #(
   parameter int NUM_CH = tim_pkg::NUM_CH
) (
   // clock and reset
   input  wire logic              mclk,
   input  wire logic              reset,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic [31:0]            prdata,
   // channel events and channel register accesses
   input  wire logic [NUM_CH-1:0] chEvent,
   input  wire logic [NUM_CH-1:0] capRead,
   input  wire logic [NUM_CH-1:0] cmpWrite,
   // timer clock and flags
   output logic                   timerTick,
   output logic [NUM_CH-1:0]      chFlags
);
   logic [2:0]        presSel_r;
   logic              fastFlagClearEnable_r;
   logic [NUM_CH-1:0] flags_r;
   logic [NUM_CH-1:0] flags_nxt;
   logic [NUM_CH-1:0] clrMask;
   logic [2:0]        selAct;
   logic              wrEn;
   logic              rdEn;
   logic              hit;
   logic [31:0]       prdata_r;

   assign hit = (paddr == tim_pkg::OFS_CTRL) || (paddr == tim_pkg::OFS_FLAGS)
             || (paddr == tim_pkg::OFS_STATUS);
   assign wrEn    = psel && penable && pwrite;
   assign rdEn    = psel && !penable && !pwrite;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !hit;

   // control register: prescale selector and fast clear enable
   always_ff @(posedge mclk) begin
      if (reset) begin
         presSel_r             <= tim_pkg::SEL_RST;
         fastFlagClearEnable_r <= 1'b0;
      end else if (wrEn && paddr == tim_pkg::OFS_CTRL) begin
         presSel_r             <= pwdata[tim_pkg::CTRL_SEL_LSB +: 3];
         fastFlagClearEnable_r <= pwdata[tim_pkg::CTRL_FFC_BIT];
      end
   end

   tim_prescaler u_pres (
      .mclk   (mclk),
      .reset  (reset),
      .selReq (presSel_r),
      .tick   (timerTick),
      .selAct (selAct)
   );

   // flag clear sources and next value per channel
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         assign clrMask[g] = (wrEn && paddr == tim_pkg::OFS_FLAGS && pwdata[g])
                          || (fastFlagClearEnable_r && (capRead[g] || cmpWrite[g]));
         assign flags_nxt[g] = chEvent[g] | (flags_r[g] & ~clrMask[g]);
      end
   endgenerate

   always_ff @(posedge mclk) begin
      if (reset) begin
         flags_r <= tim_pkg::FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end
   assign chFlags = flags_r;

   // read data captured in setup, held through access
   always_ff @(posedge mclk) begin
      if (reset) begin
         prdata_r <= tim_pkg::ZERO_WORD;
      end else if (rdEn) begin
         unique case (paddr)
            tim_pkg::OFS_CTRL:   prdata_r <= {27'h0, fastFlagClearEnable_r, 1'b0, presSel_r};
            tim_pkg::OFS_FLAGS:  prdata_r <= {24'h0, flags_r};
            tim_pkg::OFS_STATUS: prdata_r <= {29'h0, selAct};
            default:             prdata_r <= tim_pkg::ZERO_WORD;
         endcase
      end
   end
   assign prdata = prdata_r;

   a_event_sets: assert property (@(posedge mclk) disable iff (reset)
      chEvent[0] |=> flags_r[0])
      else $error("event did not set flag 0");
   a_event_wins: assert property (@(posedge mclk) disable iff (reset)
      chEvent[1] && clrMask[1] |=> flags_r[1])
      else $error("clear beat a same-cycle event");
   a_w1c_clear: assert property (@(posedge mclk) disable iff (reset)
      wrEn && paddr == tim_pkg::OFS_FLAGS && pwdata[2] && !chEvent[2] |=> !flags_r[2])
      else $error("write one did not clear flag 2");
   a_w0_keep: assert property (@(posedge mclk) disable iff (reset)
      wrEn && paddr == tim_pkg::OFS_FLAGS && !pwdata[3] && flags_r[3]
      && !(fastFlagClearEnable_r && (capRead[3] || cmpWrite[3])) |=> flags_r[3])
      else $error("write zero changed flag 3");
   a_fast_clear: assert property (@(posedge mclk) disable iff (reset)
      fastFlagClearEnable_r && capRead[4] && !chEvent[4] |=> !flags_r[4])
      else $error("fast clear missed on capture read");
   a_no_fast: assert property (@(posedge mclk) disable iff (reset)
      !fastFlagClearEnable_r && cmpWrite[5] && flags_r[5]
      && !(wrEn && paddr == tim_pkg::OFS_FLAGS) |=> flags_r[5])
      else $error("flag cleared with fast clear off");
   a_sel_applied: assert property (@(posedge mclk) disable iff (reset)
      timerTick && presSel_r != selAct |=> selAct == $past(presSel_r))
      else $error("selector not applied at zero");
   a_div_two: assert property (@(posedge mclk) disable iff (reset)
      timerTick && selAct == 3'h1 && presSel_r == 3'h1 |=> !timerTick ##1 timerTick)
      else $error("divide by two wrong");
   a_ctrl_lands: assert property (@(posedge mclk) disable iff (reset)
      wrEn && paddr == tim_pkg::OFS_CTRL |=> presSel_r == $past(pwdata[2:0]))
      else $error("selector write did not land");
   a_ready_high: assert property (@(posedge mclk) disable iff (reset)
      psel && penable |-> pready)
      else $error("access phase without ready");
   a_err_mapped: assert property (@(posedge mclk) disable iff (reset)
      psel && penable && hit |-> !pslverr)
      else $error("error on a mapped register");

   // per-channel set, clear and keep
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_chk
         a_any_set: assert property (@(posedge mclk) disable iff (reset)
            chEvent[g] |=> flags_r[g])
            else $error("event did not set its flag");
         a_any_clear: assert property (@(posedge mclk) disable iff (reset)
            wrEn && paddr == tim_pkg::OFS_FLAGS && pwdata[g] && !chEvent[g] |=> !flags_r[g])
            else $error("written one left a flag set");
         a_any_keep: assert property (@(posedge mclk) disable iff (reset)
            !clrMask[g] && flags_r[g] |=> flags_r[g])
            else $error("flag dropped with no clear");
      end
   endgenerate

   c_fast_clear: cover property (@(posedge mclk) disable iff (reset)
      fastFlagClearEnable_r && cmpWrite[0] && flags_r[0]);
   c_w1c: cover property (@(posedge mclk) disable iff (reset)
      wrEn && paddr == tim_pkg::OFS_FLAGS && |pwdata[7:0]);
   c_collide: cover property (@(posedge mclk) disable iff (reset)
      |(chEvent & clrMask));
endmodule
`default_nettype wire

// ==== dv/tb_tim_channel_flags.sv ====
// bench for the prescaler and channel event flag block
// assumes the apb slave answers with pready and is clocked at 20 MHz
`timescale 1ns/1ps
`default_nettype none
module tb_tim_channel_flags;
   logic        mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [7:0]  chEvent = 8'h00, capRead = 8'h00, cmpWrite = 8'h00, chFlags;
   logic        pready, pslverr, timerTick, err;
   int          n_errors = 0, checked = 0, cyc = 0;
   always #25 mclk = ~mclk;
   tim_channel_flags dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .chEvent(chEvent), .capRead(capRead), .cmpWrite(cmpWrite),
      .timerTick(timerTick), .chFlags(chFlags));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge mclk) penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic pulse(input logic [7:0] e, input logic [7:0] c, input logic [7:0] w);
      chEvent <= e; capRead <= c; cmpWrite <= w;
      @(posedge mclk) chEvent <= 8'h00; capRead <= 8'h00; cmpWrite <= 8'h00;
      @(posedge mclk);
   endtask
   task automatic wait_tick;
      do @(posedge mclk); while (timerTick !== 1'b1);
   endtask
   // skips one period so a change of selector has settled
   task automatic period(input int exp);
      int n;
      wait_tick();
      wait_tick();
      n = 0;
      do begin @(posedge mclk); n++; end while (timerTick !== 1'b1);
      check(n, exp);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         give_verdict();
      end
   end
   initial begin
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      @(posedge mclk);
      apb(1'b0, tim_pkg::OFS_CTRL, 32'h0); check(rd, 32'h0);
      apb(1'b0, tim_pkg::OFS_FLAGS, 32'h0); check(rd, 32'h0);
      for (int s = 0; s < 8; s++) begin
         apb(1'b1, tim_pkg::OFS_CTRL, 32'(s));
         period(1 << s);
         apb(1'b0, tim_pkg::OFS_STATUS, 32'h0); check(rd, 32'(s));
      end
      // selector change right after a tick must wait for the next one
      wait_tick();
      apb(1'b1, tim_pkg::OFS_CTRL, 32'h0);
      apb(1'b0, tim_pkg::OFS_STATUS, 32'h0); check(rd, 32'h7);
      period(1);
      pulse(8'hA5, 8'h00, 8'h00); check(chFlags, 8'hA5);
      apb(1'b1, tim_pkg::OFS_FLAGS, 32'h81); check(chFlags, 8'h24);
      apb(1'b0, tim_pkg::OFS_FLAGS, 32'h0); check(rd, 32'h24);
      pulse(8'h00, 8'h04, 8'h20); check(chFlags, 8'h24);
      apb(1'b1, tim_pkg::OFS_CTRL, 32'h10);
      pulse(8'h00, 8'h04, 8'h00); check(chFlags, 8'h20);
      pulse(8'h00, 8'h00, 8'h20); check(chFlags, 8'h00);
      pulse(8'h08, 8'h08, 8'h00); check(chFlags, 8'h08);
      pulse(8'h00, 8'h00, 8'h08); check(chFlags, 8'h00);
      pulse(8'hFF, 8'h00, 8'h00); check(chFlags, 8'hFF);
      // event lands on the same edge as the clearing write
      fork
         apb(1'b1, tim_pkg::OFS_FLAGS, 32'h18);
         begin
            @(posedge mclk) chEvent <= 8'h08;
            @(posedge mclk) chEvent <= 8'h00;
         end
      join
      check(chFlags, 8'hEF);
      apb(1'b0, 12'h00C, 32'h0);
      check(rd, 32'h0);
      check(err, 1'b1);
      give_verdict();
   end
endmodule
`default_nettype wire
